// *** hdl/esrpm_pkg.sv ***
// Shared constants for the error-correcting simple dual-port memory port map.
// Assumes one system clock; both port clocks arrive as sampled pins.
package esrpm_pkg;
    localparam int ADDR_W       = 16;
    localparam int WORD_LSB     = 6;
    localparam int WORD_MSB     = 14;
    localparam int LOC_W        = 9;
    localparam int DEPTH        = 512;
    localparam int DATA_W       = 64;
    localparam int HALF_W       = 32;
    localparam int HALF_PAR_W   = 4;
    localparam int CHECK_W      = 8;
    localparam int HAM_W        = 7;
    localparam int CODE_POS     = 71;
    localparam int BYTE_EN_W    = 8;
    localparam int RD_BYTE_EN_W = 4;
    localparam int INJ_LO_BIT   = 30;
    localparam int INJ_HI_BIT   = 62;
    localparam int SYNC_STAGES  = 3;
    localparam int NUM_PORTS    = 2;
    localparam int RD_PORT      = 0;
    localparam int WR_PORT      = 1;
    localparam logic [LOC_W-1:0]   LOC_RESET   = 9'h000;
    localparam logic [CHECK_W-1:0] CHECK_RESET = 8'h00;
    localparam logic [35:0]        INIT_RESET  = 36'h000000000;
endpackage

// *** hdl/esrpm_top.sv ***
// Error-correcting simple dual-port 512 x 64 memory with its port mapping.
// Assumes both port clocks are slow pins sampled by sys_clk_in; port inputs
// must stay stable until the sampled clock edge has been seen.
// Function
// - Low-half write data is stored at the write-side address word.
// - Low-half parity inputs are stored at the write-side address word only with ECC write off.
// - First-port address is the read address; only bits 14 to 6 select.
// - Second-port address is the write address; only bits 14 to 6 decode.
// - Second-port enables are byte write enables; user drives all high.
// - First-port enable gates every read.
// - Second-port enable gates every write.
// - Output register reset loads init value; precedence picks reset or enable.
// - Without output register, latch reset loads init value on an enabled read; user drives it per read.
// - First-port clock times reads, second-port clock times writes, independently.
// - Output register enable gates output register updates.
// - Chain inputs are ignored and chain outputs stay quiet here.
// - Low-half read data shows the word at the read address.
// - Low-half read parity shows check bits of the word read.
// - Memory holds 512 words of 64 bits with eight check bits each.
// - Reads correct and flag single errors, flag double errors, memory untouched.
// - With ECC write on, single inject flips data bit 30; double inject flips bits 30 and 62.
// - Read-back location names the word on the outputs in the same cycle; latch and output register resets leave it unchanged.
`timescale 1ns/1ps
module esrpm_top #(
    parameter bit          OUT_REG_OPTION    = 1'b0,
    parameter bit          ECC_WRITE_ENABLE  = 1'b1,
    parameter bit          ECC_READ_ENABLE   = 1'b1,
    parameter bit          RESET_PRECEDENCE  = 1'b1,
    parameter logic [35:0] FIRST_INIT_VALUE  = esrpm_pkg::INIT_RESET,
    parameter logic [35:0] SECOND_INIT_VALUE = esrpm_pkg::INIT_RESET
) (
    input  wire logic        sys_clk_in,
    input  wire logic        srst_in,
    input  wire logic        first_port_clock_in,
    input  wire logic        second_port_clock_in,
    input  wire logic [15:0] read_side_address_in,
    input  wire logic [15:0] write_side_address_in,
    input  wire logic [31:0] low_half_write_data_in,
    input  wire logic [31:0] high_half_write_data_in,
    input  wire logic [3:0]  low_half_write_parity_in,
    input  wire logic [3:0]  high_half_write_parity_in,
    input  wire logic [3:0]  first_port_byte_write_enables_in,
    input  wire logic [7:0]  second_port_byte_write_enables_in,
    input  wire logic        first_port_enable_read_in,
    input  wire logic        second_port_enable_write_in,
    input  wire logic        first_port_outreg_reset_in,
    input  wire logic        first_port_latch_reset_in,
    input  wire logic        second_port_outreg_reset_in,
    input  wire logic        second_port_latch_reset_in,
    input  wire logic        first_port_outreg_clock_enable_in,
    input  wire logic        second_port_outreg_clock_enable_in,
    input  wire logic        first_port_chain_in_in,
    input  wire logic        inject_single_fault_in,
    input  wire logic        inject_double_fault_in,
    output logic [31:0]      low_half_read_data_out,
    output logic [31:0]      high_half_read_data_out,
    output logic [3:0]       low_half_read_parity_out,
    output logic [3:0]       high_half_read_parity_out,
    output logic             single_fault_corrected_flag_out,
    output logic             double_fault_detected_flag_out,
    output logic [8:0]       read_back_location_out,
    output logic [7:0]       generated_check_bits_out,
    output logic             first_port_chain_out_out
);
    localparam int DW = esrpm_pkg::DATA_W;
    localparam int CW = esrpm_pkg::CHECK_W;
    localparam int LW = esrpm_pkg::LOC_W;
    localparam int NP = esrpm_pkg::NUM_PORTS;

    // Eight check bits: seven Hamming bits and one overall parity bit.
    function automatic logic [CW-1:0] esrpm_encode(input logic [DW-1:0] d);
        logic [esrpm_pkg::CODE_POS:1] cw;
        logic [CW-1:0]                c;
        int                           j;
        cw = '0;
        c  = '0;
        j  = 0;
        for (int p = 1; p <= esrpm_pkg::CODE_POS; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p] = d[j];
                j++;
            end
        end
        for (int b = 0; b < esrpm_pkg::HAM_W; b++) begin
            for (int p = 1; p <= esrpm_pkg::CODE_POS; p++) begin
                if (p[b]) begin
                    c[b] = c[b] ^ cw[p];
                end
            end
        end
        c[CW-1] = (^d) ^ (^c[esrpm_pkg::HAM_W-1:0]);
        return c;
    endfunction

    // Flips the data bit sitting at code position syn, if it is a data position.
    function automatic logic [DW-1:0] esrpm_fix(input logic [DW-1:0] d,
                                                input logic [6:0]    syn);
        logic [DW-1:0] r;
        int            j;
        r = d;
        j = 0;
        for (int p = 1; p <= esrpm_pkg::CODE_POS; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (p == int'(syn)) begin
                    r[j] = ~d[j];
                end
                j++;
            end
        end
        return r;
    endfunction

    // Port clock sampling: three stages, a level counts when stages two and three agree.
    logic [NP-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, edge_q, edge_d;

    always_comb begin
        for (int i = 0; i < NP; i++) begin
            lvl_d[i]  = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
            edge_d[i] = lvl_d[i] & ~lvl_q[i];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            lvl_q  <= '0;
            edge_q <= '0;
        end else begin
            s1_q   <= {second_port_clock_in, first_port_clock_in};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            lvl_q  <= lvl_d;
            edge_q <= edge_d;
        end
    end

    logic rd_edge, wr_edge;
    assign rd_edge = edge_q[esrpm_pkg::RD_PORT];
    assign wr_edge = edge_q[esrpm_pkg::WR_PORT];

    // Write side.
    logic [DW+CW-1:0] mem [esrpm_pkg::DEPTH];
    logic [LW-1:0]    wr_idx;
    logic [DW-1:0]    wr_word, wr_old, wr_merged, wr_stored, inj_mask;
    logic [CW-1:0]    wr_check, gen_check_q, gen_check_d;
    logic             wr_go;

    always_comb begin
        wr_idx  = write_side_address_in[esrpm_pkg::WORD_MSB:esrpm_pkg::WORD_LSB];
        wr_word = {high_half_write_data_in, low_half_write_data_in};
        wr_old  = mem[wr_idx][DW-1:0];
        for (int b = 0; b < esrpm_pkg::BYTE_EN_W; b++) begin
            wr_merged[b*8 +: 8] = second_port_byte_write_enables_in[b] ?
                                  wr_word[b*8 +: 8] : wr_old[b*8 +: 8];
        end
        inj_mask = '0;
        inj_mask[esrpm_pkg::INJ_LO_BIT] = inject_single_fault_in | inject_double_fault_in;
        inj_mask[esrpm_pkg::INJ_HI_BIT] = inject_double_fault_in;
        wr_check  = ECC_WRITE_ENABLE ? esrpm_encode(wr_merged) :
                    {high_half_write_parity_in, low_half_write_parity_in};
        wr_stored = wr_merged ^ (ECC_WRITE_ENABLE ? inj_mask : '0);
        wr_go     = wr_edge & second_port_enable_write_in;
        gen_check_d = wr_go ? esrpm_encode(wr_merged) : gen_check_q;
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            gen_check_q <= esrpm_pkg::CHECK_RESET;
        end else begin
            gen_check_q <= gen_check_d;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (wr_go) begin
            mem[wr_idx] <= {wr_check, wr_stored};
        end
    end

    // Read side: decode, output latch and optional output register.
    logic [LW-1:0]    rd_idx;
    logic [DW+CW-1:0] rd_raw;
    logic [6:0]       syn;
    logic [CW-1:0]    rd_code;
    logic             ovr, dec_single, dec_double, rd_go;
    logic [DW-1:0]    dec_data;
    logic [DW+CW-1:0] lat_q, lat_d, oreg_q, oreg_d;
    logic [1:0]       lflag_q, lflag_d, oflag_q, oflag_d;
    logic [LW-1:0]    lloc_q, lloc_d, oloc_q, oloc_d;
    logic [DW+CW-1:0] init_word;
    logic             oreg_rst;

    assign init_word = {SECOND_INIT_VALUE[35:32], FIRST_INIT_VALUE[35:32],
                        SECOND_INIT_VALUE[31:0], FIRST_INIT_VALUE[31:0]};

    always_comb begin
        rd_idx     = read_side_address_in[esrpm_pkg::WORD_MSB:esrpm_pkg::WORD_LSB];
        rd_raw     = mem[rd_idx];
        rd_code    = esrpm_encode(rd_raw[DW-1:0]);
        syn        = rd_code[6:0] ^ rd_raw[DW+6:DW];
        ovr        = ^rd_raw;
        dec_single = ECC_READ_ENABLE & ovr;
        dec_double = ECC_READ_ENABLE & ~ovr & (syn != 7'h00);
        dec_data   = dec_single ? esrpm_fix(rd_raw[DW-1:0], syn) : rd_raw[DW-1:0];
        rd_go      = rd_edge & first_port_enable_read_in;
        lat_d      = lat_q;
        lflag_d    = lflag_q;
        lloc_d     = lloc_q;
        if (rd_go) begin
            if (!OUT_REG_OPTION && first_port_latch_reset_in) begin
                lat_d   = init_word;
                lflag_d = 2'h0;
            end else begin
                lat_d   = {rd_raw[DW+CW-1:DW], dec_data};
                lflag_d = {dec_double, dec_single};
                lloc_d  = rd_idx;
            end
        end
        oreg_rst = first_port_outreg_reset_in &
                   (RESET_PRECEDENCE | first_port_outreg_clock_enable_in);
        oreg_d   = oreg_q;
        oflag_d  = oflag_q;
        oloc_d   = oloc_q;
        if (rd_edge && OUT_REG_OPTION) begin
            if (oreg_rst) begin
                oreg_d  = init_word;
                oflag_d = 2'h0;
            end else if (first_port_outreg_clock_enable_in) begin
                oreg_d  = lat_q;
                oflag_d = lflag_q;
                oloc_d  = lloc_q;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            lat_q   <= {esrpm_pkg::INIT_RESET[35:32], esrpm_pkg::INIT_RESET[35:32],
                        esrpm_pkg::INIT_RESET[31:0], esrpm_pkg::INIT_RESET[31:0]};
            oreg_q  <= {esrpm_pkg::INIT_RESET[35:32], esrpm_pkg::INIT_RESET[35:32],
                        esrpm_pkg::INIT_RESET[31:0], esrpm_pkg::INIT_RESET[31:0]};
            lflag_q <= 2'h0;
            oflag_q <= 2'h0;
            lloc_q  <= esrpm_pkg::LOC_RESET;
            oloc_q  <= esrpm_pkg::LOC_RESET;
        end else begin
            lat_q   <= lat_d;
            oreg_q  <= oreg_d;
            lflag_q <= lflag_d;
            oflag_q <= oflag_d;
            lloc_q  <= lloc_d;
            oloc_q  <= oloc_d;
        end
    end

    logic [DW+CW-1:0] out_word;
    logic [1:0]       out_flag;
    assign out_word = OUT_REG_OPTION ? oreg_q : lat_q;
    assign out_flag = OUT_REG_OPTION ? oflag_q : lflag_q;

    assign low_half_read_data_out          = out_word[31:0];
    assign high_half_read_data_out         = out_word[63:32];
    assign low_half_read_parity_out        = out_word[67:64];
    assign high_half_read_parity_out       = out_word[71:68];
    assign single_fault_corrected_flag_out = out_flag[0];
    assign double_fault_detected_flag_out  = out_flag[1];
    assign read_back_location_out          = OUT_REG_OPTION ? oloc_q : lloc_q;
    assign generated_check_bits_out        = gen_check_q;
    assign first_port_chain_out_out        = 1'b0;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    a_write_lands: assert property ((wr_go && second_port_byte_write_enables_in == 8'hFF
        && !inject_single_fault_in && !inject_double_fault_in)
        |=> mem[$past(wr_idx)][DW-1:0] == $past(wr_word))
        else $error("Written word not found at write address.");
    a_parity_kept: assert property ((wr_go && !ECC_WRITE_ENABLE)
        |=> mem[$past(wr_idx)][DW+CW-1:DW] == {$past(high_half_write_parity_in),
                                               $past(low_half_write_parity_in)})
        else $error("Parity inputs not stored.");
    a_read_location: assert property ((rd_go && !first_port_latch_reset_in)
        |=> lloc_q == $past(read_side_address_in[14:6]))
        else $error("Read word not chosen by address bits 14 to 6.");
    a_write_gated: assert property ((!(wr_edge && second_port_enable_write_in))
        |=> mem[$past(wr_idx)] === $past(mem[wr_idx]))
        else $error("Memory changed without write enable.");
    a_read_gated: assert property ((!rd_go) |=> $stable(lat_q) && $stable(lloc_q))
        else $error("Read latch changed without read enable.");
    a_outreg_reset: assert property ((rd_edge && OUT_REG_OPTION && oreg_rst)
        |=> oreg_q == init_word && oflag_q == 2'h0)
        else $error("Output register reset did not load init value.");
    a_outreg_hold: assert property ((rd_edge && OUT_REG_OPTION
        && !first_port_outreg_clock_enable_in && !first_port_outreg_reset_in)
        |=> $stable(oreg_q))
        else $error("Output register moved without its enable.");
    a_latch_reset: assert property ((rd_go && !OUT_REG_OPTION && first_port_latch_reset_in)
        |=> low_half_read_data_out == FIRST_INIT_VALUE[31:0])
        else $error("Latch reset did not load init value.");
    a_flags_exclusive: assert property (!(lflag_q[0] && lflag_q[1]))
        else $error("Single and double error flagged together.");
    a_edge_sampled: assert property (wr_edge |-> $past(s3_q[1], 2) == 1'b0)
        else $error("Write strobe without a sampled clock rise.");
    a_chain_quiet: assert property (first_port_chain_out_out == 1'b0)
        else $error("Chain output driven.");

    c_write_seen: cover property (wr_go ##[1:40] rd_go);
    c_single_fix: cover property (rd_go && dec_single);
    c_double_seen: cover property (rd_go && dec_double);
endmodule

// *** verif/esrpm_user.sv ***
// Fabric user logic model that drives the memory's write and read port pins.
// Assumes clk_in is the system clock and that the testbench calls its tasks.
`timescale 1ns/1ps
module esrpm_user (
    input  wire logic        clk_in,
    output logic             rclk_out,
    output logic             wclk_out,
    output logic [15:0]      raddr_out,
    output logic [15:0]      waddr_out,
    output logic [63:0]      wdata_out,
    output logic [7:0]       wpar_out,
    output logic [7:0]       wbe_out,
    output logic             ren_out,
    output logic             wen_out,
    output logic             lrst_out,
    output logic             inj_s_out,
    output logic             inj_d_out
);
    initial begin
        rclk_out  = 1'b0;
        wclk_out  = 1'b0;
        raddr_out = 16'h0000;
        waddr_out = 16'h0000;
        wdata_out = 64'h0;
        wpar_out  = 8'h00;
        wbe_out   = 8'hFF;
        ren_out   = 1'b0;
        wen_out   = 1'b0;
        lrst_out  = 1'b0;
        inj_s_out = 1'b0;
        inj_d_out = 1'b0;
    end

    // Raises one port clock long enough for the sampled edge to be taken.
    task automatic strobe(input bit rd);
        @(negedge clk_in);
        if (rd) begin
            rclk_out = 1'b1;
        end else begin
            wclk_out = 1'b1;
        end
        repeat (7) @(negedge clk_in);
        rclk_out = 1'b0;
        wclk_out = 1'b0;
        repeat (4) @(negedge clk_in);
    endtask

    // Released address, data and parity lines show the inverse so stale values cannot pass; enables and injects drop to 0.
    task automatic write_word(input logic [15:0] a, input logic [63:0] d,
                              input logic en, input logic si, input logic di);
        @(negedge clk_in);
        waddr_out = a;
        wdata_out = d;
        wen_out   = en;
        inj_s_out = si;
        inj_d_out = di;
        strobe(1'b0);
        waddr_out = ~a;
        wdata_out = ~d;
        wpar_out  = ~wpar_out;
        wen_out   = 1'b0;
        inj_s_out = 1'b0;
        inj_d_out = 1'b0;
    endtask

    task automatic read_word(input logic [15:0] a, input logic en, input logic lr);
        @(negedge clk_in);
        raddr_out = a;
        ren_out   = en;
        lrst_out  = lr;
        strobe(1'b1);
        raddr_out = ~a;
        ren_out   = 1'b0;
        lrst_out  = 1'b0;
    endtask
endmodule

// *** verif/tb.sv ***
// Self-checking testbench for the error-correcting simple dual-port memory.
// Assumes the design's default parameters, with the output register on in the second copy, and the user logic model.
`timescale 1ns/1ps
module tb;
    localparam logic [63:0] D1 = 64'h0123456789ABCDEF;
    localparam logic [63:0] D2 = 64'hFEDCBA9876543210;
    localparam logic [63:0] D3 = 64'h5A5A5A5AC3C3C3C3;
    localparam logic [63:0] D4 = 64'h8000000100000001;
    localparam logic [63:0] D5 = 64'h4000000040000000;
    localparam logic [63:0] D6 = 64'hBFFFFFFFBFFFFFFF;
    logic        clk   = 1'b0;
    logic        srst  = 1'b1;
    logic        chain = 1'b0;
    logic        rce   = 1'b1;
    logic        rclk, wclk, ren, wen, lrst, inj_s, inj_d;
    logic [15:0] raddr, waddr;
    logic [63:0] wdata;
    logic [7:0]  wpar, wbe;
    wire  [63:0] rdata;
    wire  [7:0]  rpar, gen;
    wire  [8:0]  loc;
    wire         sflag, dflag, chain_o;
    wire  [63:0] rdata_r;
    wire  [8:0]  loc_r;
    int          num_errors = 0;
    int          cmp_count  = 0;

    always #5 clk = ~clk;

    esrpm_user user (.clk_in(clk), .rclk_out(rclk), .wclk_out(wclk), .raddr_out(raddr),
        .waddr_out(waddr), .wdata_out(wdata), .wpar_out(wpar), .wbe_out(wbe),
        .ren_out(ren), .wen_out(wen), .lrst_out(lrst), .inj_s_out(inj_s),
        .inj_d_out(inj_d));

    esrpm_top uut (
        .sys_clk_in(clk),
        .srst_in(srst),
        .first_port_clock_in(rclk),
        .second_port_clock_in(wclk),
        .read_side_address_in(raddr),
        .write_side_address_in(waddr),
        .low_half_write_data_in(wdata[31:0]),
        .high_half_write_data_in(wdata[63:32]),
        .low_half_write_parity_in(wpar[3:0]),
        .high_half_write_parity_in(wpar[7:4]),
        .first_port_byte_write_enables_in(4'h0),
        .second_port_byte_write_enables_in(wbe),
        .first_port_enable_read_in(ren),
        .second_port_enable_write_in(wen),
        .first_port_outreg_reset_in(1'b0),
        .first_port_latch_reset_in(lrst),
        .second_port_outreg_reset_in(1'b0),
        .second_port_latch_reset_in(1'b0),
        .first_port_outreg_clock_enable_in(rce),
        .second_port_outreg_clock_enable_in(1'b0),
        .first_port_chain_in_in(chain),
        .inject_single_fault_in(inj_s),
        .inject_double_fault_in(inj_d),
        .low_half_read_data_out(rdata[31:0]),
        .high_half_read_data_out(rdata[63:32]),
        .low_half_read_parity_out(rpar[3:0]),
        .high_half_read_parity_out(rpar[7:4]),
        .single_fault_corrected_flag_out(sflag),
        .double_fault_detected_flag_out(dflag),
        .read_back_location_out(loc),
        .generated_check_bits_out(gen),
        .first_port_chain_out_out(chain_o)
    );

    // Second copy with the output register in use; it sees the same writes and reads.
    esrpm_top #(.OUT_REG_OPTION(1'b1)) uut_reg (
        .sys_clk_in(clk),
        .srst_in(srst),
        .first_port_clock_in(rclk),
        .second_port_clock_in(wclk),
        .read_side_address_in(raddr),
        .write_side_address_in(waddr),
        .low_half_write_data_in(wdata[31:0]),
        .high_half_write_data_in(wdata[63:32]),
        .low_half_write_parity_in(wpar[3:0]),
        .high_half_write_parity_in(wpar[7:4]),
        .first_port_byte_write_enables_in(4'h0),
        .second_port_byte_write_enables_in(wbe),
        .first_port_enable_read_in(ren),
        .second_port_enable_write_in(wen),
        .first_port_outreg_reset_in(1'b0),
        .first_port_latch_reset_in(lrst),
        .second_port_outreg_reset_in(1'b0),
        .second_port_latch_reset_in(1'b0),
        .first_port_outreg_clock_enable_in(rce),
        .second_port_outreg_clock_enable_in(1'b0),
        .first_port_chain_in_in(chain),
        .inject_single_fault_in(inj_s),
        .inject_double_fault_in(inj_d),
        .low_half_read_data_out(rdata_r[31:0]),
        .high_half_read_data_out(rdata_r[63:32]),
        .low_half_read_parity_out(),
        .high_half_read_parity_out(),
        .single_fault_corrected_flag_out(),
        .double_fault_detected_flag_out(),
        .read_back_location_out(loc_r),
        .generated_check_bits_out(),
        .first_port_chain_out_out()
    );

    // Check bits at power-of-two positions 1..71, bit 7 is overall parity.
    function automatic logic [7:0] ecc(input logic [63:0] d);
        logic [6:0] syn;
        int         k;
        syn = 7'h00;
        k = 0;
        for (int p = 1; p < 72; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (d[k]) syn = syn ^ p[6:0];
                k++;
            end
        end
        return {^d ^ ^syn, syn};
    endfunction

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr_chk(input logic [15:0] a, input logic [63:0] d,
                          input logic si, input logic di);
        user.write_word(a, d, 1'b1, si, di);
        check("gen", 64'(gen), 64'(ecc(d)));
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [63:0] d,
                          input logic s, input logic db);
        user.read_word(a, 1'b1, 1'b0);
        if (!db) check("data", rdata, d);
        check("par", 64'(rpar), 64'(ecc(d)));
        check("sflag", 64'(sflag), 64'(s));
        check("dflag", 64'(dflag), 64'(db));
        check("loc", 64'(loc), 64'(a[14:6]));
    endtask

    // Ignored address bits differ between write and read; edge words used.
    task automatic t_map();
        wr_chk(16'h817F, D1, 1'b0, 1'b0);
        wr_chk(16'hFFFF, D2, 1'b0, 1'b0);
        wr_chk(16'h0000, D3, 1'b0, 1'b0);
        rd_chk(16'h0140, D1, 1'b0, 1'b0);
        rd_chk(16'h7FC0, D2, 1'b0, 1'b0);
        rd_chk(16'h803F, D3, 1'b0, 1'b0);
    endtask

    task automatic t_enable();
        wr_chk(16'h01C0, D4, 1'b0, 1'b0);
        user.write_word(16'h01C0, D2, 1'b0, 1'b0, 1'b0);
        rd_chk(16'h01C0, D4, 1'b0, 1'b0);
        user.read_word(16'h0240, 1'b0, 1'b0);
        check("loc", 64'(loc), 64'h7);
        user.write_word(16'h01C0, D3, 1'b1, 1'b0, 1'b0);
        check("data", rdata, D4);
    endtask

    task automatic t_inject();
        wr_chk(16'h0500, D5, 1'b1, 1'b0);
        rd_chk(16'h0500, D5, 1'b1, 1'b0);
        rd_chk(16'h0500, D5, 1'b1, 1'b0);
        wr_chk(16'h0540, D5, 1'b0, 1'b1);
        rd_chk(16'h0540, D5, 1'b0, 1'b1);
        wr_chk(16'h0580, D6, 1'b1, 1'b1);
        rd_chk(16'h0580, D6, 1'b0, 1'b1);
    endtask

    task automatic t_latch();
        rd_chk(16'h0500, D5, 1'b1, 1'b0);
        user.read_word(16'h0140, 1'b1, 1'b1);
        check("data", rdata, {2{esrpm_pkg::INIT_RESET[31:0]}});
        check("par", 64'(rpar), 64'h0);
        check("sflag", 64'(sflag), 64'h0);
        check("loc", 64'(loc), 64'h14);
        rd_chk(16'h0140, D1, 1'b0, 1'b0);
    endtask

    task automatic t_chain();
        @(negedge clk);
        chain = 1'b1;
        rce   = 1'b0;
        rd_chk(16'h0000, D3, 1'b0, 1'b0);
        check("chain", 64'(chain_o), 64'h0);
        chain = 1'b0;
        rce   = 1'b1;
    endtask

    // Register mode: a read lands in the register at the next read-clock rise with the register enable high, read enable or not.
    task automatic t_outreg();
        user.read_word(16'h0140, 1'b1, 1'b0);
        user.read_word(16'h0140, 1'b0, 1'b0);
        check("reg data", rdata_r, D1);
        check("reg loc", 64'(loc_r), 64'h5);
        @(negedge clk);
        rce = 1'b0;
        user.read_word(16'h7FC0, 1'b1, 1'b0);
        user.read_word(16'h7FC0, 1'b0, 1'b0);
        check("reg hold", rdata_r, D1);
        @(negedge clk);
        rce = 1'b1;
        user.read_word(16'h7FC0, 1'b0, 1'b0);
        check("reg data", rdata_r, D2);
        check("reg loc", 64'(loc_r), 64'h1FF);
    endtask

    initial begin
        repeat (8) @(negedge clk);
        srst = 1'b0;
        t_map();
        t_enable();
        t_inject();
        t_latch();
        t_chain();
        t_outreg();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule
